// [logic/host_map_pkg.sv]
package host_map_pkg;

  // ==========================================================
  // Register space geometry
  // ==========================================================
  localparam int        CSR_WORDS     = 80;       // 160 bytes of registers
  localparam logic [7:0] CSR_BYTES    = 8'ha0;    // End of register space
  localparam logic [7:0] UNBANKED_BASE = 8'h80;   // Unbanked-only region
  localparam logic [4:0] COMMON_LO    = 5'h16;    // Common alias window start
  localparam int        BANK_W        = 2;        // Four banks
  localparam int        OFF_W         = 5;        // 32 bytes per bank

  // ==========================================================
  // Main memory map, byte addresses
  // ==========================================================
  localparam logic [14:0] BUF_END     = 15'h5fff; // 24 Kbyte buffer
  localparam logic [14:0] CRYPTO_LO   = 15'h7800;
  localparam logic [14:0] CRYPTO_HI   = 15'h7c4f;
  localparam logic [14:0] PSFR_BASE   = 15'h7e00; // Plain register window
  localparam logic [14:0] PSET_BASE   = 15'h7ea0; // Bit-set alias window
  localparam logic [14:0] PCLR_BASE   = 15'h7f40; // Bit-clear alias window
  localparam logic [14:0] PCLR_END    = 15'h7fdf;

  // ==========================================================
  // MAC-side register word indices
  // ==========================================================
  localparam logic [6:0] MAC_A_LO     = 7'h20;
  localparam logic [6:0] MAC_A_HI     = 7'h2a;
  localparam logic [6:0] MAC_B_LO     = 7'h30;
  localparam logic [6:0] MAC_B_HI     = 7'h35;

  // ==========================================================
  // Operations and region kinds
  // ==========================================================
  localparam logic [1:0] OP_WRITE     = 2'h0;
  localparam logic [1:0] OP_SET       = 2'h1;
  localparam logic [1:0] OP_CLR       = 2'h2;

  typedef enum logic [2:0] {
    RGN_NONE = 3'b001,   // Unimplemented, crypto: reads zero
    RGN_BUF  = 3'b010,   // Packet buffer
    RGN_CSR  = 3'b100    // Control and status registers
  } region_t;

endpackage

// [logic/sfr_word_mem.sv]
module csr_word_mem #(
  parameter int WORDS  = 80,
  parameter int IDX_W  = 7,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Masked write port
  input  wire logic              wr_en_i,
  input  wire logic [IDX_W-1:0]  wr_idx_i,
  input  wire logic [DATA_W-1:0] wr_mask_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // Read port, registered data
  input  wire logic [IDX_W-1:0]  rd_idx_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [DATA_W-1:0] mem_ff [WORDS];   // Register words

  // Masked bit update; only masked bits change
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en_i && (int'(wr_idx_i) < WORDS)) begin
      mem_ff[wr_idx_i] <= (mem_ff[wr_idx_i] & ~wr_mask_i) |
                          (wr_data_i & wr_mask_i);
    end
  end

  // Registered read; out of range reads as zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (int'(rd_idx_i) < WORDS) begin
      rd_data_o <= mem_ff[rd_idx_i];
    end else begin
      rd_data_o <= '0;
    end
  end

endmodule

// [logic/host_register_address_map.sv]
// How it works
// R1: Parallel mode: main space plus PHY space.
// R2: Main space 32 Kbytes, buffer lowest 24K.
// R3: Parallel registers decoded above crypto region.
// R4: Set and clear alias windows above registers.
// R5: All but crypto region directly accessible.
// R6: Crypto region at 7800h through 7C4Fh.
// R7: Sixteen-bit modes address buffer by word.
// R8: Eight-bit modes address buffer by byte.
// R9: Buffer pointers always count in bytes.
// R10: Registers reachable with AD<14:9> all high.
// R11: PHY registers only via management path.
// R12: Registers 16 bits, two bytes when byte-wide.
// R13: Low byte sits at lower address.
// R14: Unimplemented locations read as zero.
// R15: Host avoids writing reserved locations.
// R16: Primary registers accept any order, alignment.
// R17: MAC registers ignore set and clear.
// R18: MAC low byte staged, high byte commits.
// R19: Host writes MAC words with both lanes.
// R20: Host never interleaves MAC byte writes.
// R21: Serial banks are 32 bytes, 5-bit offset.
// R22: Unbanked serial uses linear 8-bit address.
// R23: Serial register space is 160 bytes.
// R24: Offsets 16h-1Fh alias common registers.
// R25: 80h-9Fh reachable only unbanked.
// R26: Banked address is bank times 32 plus offset.
module host_register_address_map (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Interface selection
  input  wire logic        par_mode_i,
  input  wire logic        par_wide_i,
  // Parallel host port request
  input  wire logic        par_req_i,
  input  wire logic        par_wr_i,
  input  wire logic [14:0] par_addr_i,
  input  wire logic [1:0]  par_be_i,
  input  wire logic [15:0] par_wdata_i,
  // Serial register request
  input  wire logic        ser_req_i,
  input  wire logic        ser_wr_i,
  input  wire logic [1:0]  ser_op_i,
  input  wire logic        ser_banked_i,
  input  wire logic [1:0]  ser_bank_i,
  input  wire logic [4:0]  ser_off_i,
  input  wire logic [7:0]  ser_addr_i,
  input  wire logic [7:0]  ser_wdata_i,
  // Answer
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_rdata_o,
  // Packet buffer port
  output logic             buf_req_o,
  output logic             buf_wr_o,
  output logic [14:0]      buf_addr_o,
  output logic [1:0]       buf_be_o,
  output logic [15:0]      buf_wdata_o,
  input  wire logic [15:0] buf_rdata_i,
  // MAC byte staging status
  output logic             mac_pend_o
);

  // ==========================================================
  // Request selection
  // ==========================================================
  wire        req_w    = par_mode_i ? par_req_i : ser_req_i;  // Active req
  wire        wr_w     = par_mode_i ? par_wr_i : ser_wr_i;    // Write flag
  wire        wide_w   = par_mode_i & par_wide_i;             // 16-bit port
  wire [7:0]  bdat_w   = par_mode_i ? par_wdata_i[7:0] : ser_wdata_i;

  // ==========================================================
  // Parallel decode
  // ==========================================================
  // R7: word address doubles to a byte address
  // R8: byte modes pass the address unchanged
  // R9: buffer side always sees a byte address
  wire [14:0] par_byte_w = par_wide_i ? {par_addr_i[13:0], 1'b0}
                                      : par_addr_i;
  // R2: buffer is the lowest 24 Kbytes
  wire        p_buf_w    = (par_byte_w <= host_map_pkg::BUF_END);
  // R6: crypto window decoded only to refuse it
  wire        p_cry_w    = (par_byte_w >= host_map_pkg::CRYPTO_LO) &&
                           (par_byte_w <= host_map_pkg::CRYPTO_HI);
  // R3: register window above the crypto area
  // R10: whole window has bits 14:9 set
  wire        p_csr_w    = (par_byte_w >= host_map_pkg::PSFR_BASE) &&
                           (par_byte_w <  host_map_pkg::PSET_BASE);
  // R4: set and clear alias windows
  wire        p_set_w    = (par_byte_w >= host_map_pkg::PSET_BASE) &&
                           (par_byte_w <  host_map_pkg::PCLR_BASE);
  wire        p_clr_w    = (par_byte_w >= host_map_pkg::PCLR_BASE) &&
                           (par_byte_w <= host_map_pkg::PCLR_END);
  wire [14:0] p_base_w   = p_set_w ? host_map_pkg::PSET_BASE :
                           p_clr_w ? host_map_pkg::PCLR_BASE :
                                     host_map_pkg::PSFR_BASE;
  wire [14:0] p_off_w    = par_byte_w - p_base_w;   // Offset in window
  wire [1:0]  p_op_w     = p_set_w ? host_map_pkg::OP_SET :
                           p_clr_w ? host_map_pkg::OP_CLR :
                                     host_map_pkg::OP_WRITE;

  // ==========================================================
  // Serial decode
  // ==========================================================
  // R21: 5-bit offset inside the selected bank
  // R26: bank number forms the upper address bits
  // R25: banked form cannot reach 80h and above
  wire [7:0]  s_bank_w   = {1'b0, ser_bank_i, ser_off_i};
  // R22: unbanked opcodes use the linear address
  wire [7:0]  s_lin_w    = ser_banked_i ? s_bank_w : ser_addr_i;
  // R23: 160 bytes of registers, rest unimplemented
  wire        s_csr_w    = (s_lin_w < host_map_pkg::CSR_BYTES);

  // ==========================================================
  // Common register addressing
  // ==========================================================
  wire [7:0]  lin_w      = par_mode_i ? p_off_w[7:0] : s_lin_w;
  // R24: upper ten bytes of every bank fold onto bank 0
  wire        common_w   = (lin_w < host_map_pkg::UNBANKED_BASE) &&
                           (lin_w[4:0] >= host_map_pkg::COMMON_LO);
  wire [7:0]  canon_w    = common_w ? {3'b000, lin_w[4:0]} : lin_w;
  // R12: two bytes per register word
  wire [6:0]  idx_w      = canon_w[7:1];
  // R13: odd byte is the high half
  wire        hi_w       = canon_w[0];
  wire        is_csr_w   = par_mode_i ? (p_csr_w | p_set_w | p_clr_w)
                                      : s_csr_w;
  // R1: only the main space decodes here
  // R11: no host path into the PHY space
  // R5: buffer and registers direct, crypto never
  wire        is_buf_w   = par_mode_i & p_buf_w & ~p_cry_w;
  wire [1:0]  op_w       = par_mode_i ? p_op_w : ser_op_i;
  wire        is_mac_w   = ((idx_w >= host_map_pkg::MAC_A_LO) &&
                            (idx_w <= host_map_pkg::MAC_A_HI)) ||
                           ((idx_w >= host_map_pkg::MAC_B_LO) &&
                            (idx_w <= host_map_pkg::MAC_B_HI));

  // ==========================================================
  // Byte lanes and write data
  // ==========================================================
  wire [1:0]  lanes_w    = wide_w ? par_be_i :
                           ((par_mode_i ? par_byte_w[0] : hi_w)
                              ? 2'b10 : 2'b01);
  wire [1:0]  rlanes_w   = wide_w ? par_be_i : (hi_w ? 2'b10 : 2'b01);
  wire [15:0] wdat16_w   = wide_w ? par_wdata_i : {bdat_w, bdat_w};
  wire [15:0] lmask_w    = {{8{rlanes_w[1]}}, {8{rlanes_w[0]}}};

  // ==========================================================
  // MAC byte staging
  // ==========================================================
  logic       mac_pend_ff;   // Low byte waiting for its high byte
  logic [6:0] mac_idx_ff;    // Word that the low byte belongs to
  logic [7:0] mac_lo_ff;     // Staged low byte
  logic       nxt_mac_pend;

  wire        csr_wr_w   = req_w & wr_w & is_csr_w;
  wire        plain_w    = (op_w == host_map_pkg::OP_WRITE);
  // R18: low byte of a MAC word only stages
  wire        mac_lo_w   = csr_wr_w & is_mac_w & ~wide_w & plain_w & ~hi_w;
  // R18: matching high byte commits the word
  // R20: a stale stage never pairs with another word
  wire        mac_hi_w   = csr_wr_w & is_mac_w & ~wide_w & plain_w & hi_w &
                           mac_pend_ff & (mac_idx_ff == idx_w);
  // R19: wide MAC write needs both lanes
  wire        mac_wide_w = csr_wr_w & is_mac_w & wide_w & plain_w &
                           (par_be_i == 2'h3);
  // R16: primary registers take any byte, any order
  wire        e_wr_w     = csr_wr_w & ~is_mac_w;
  // R17: set and clear on MAC words do nothing
  wire        mem_we_w   = e_wr_w | mac_hi_w | mac_wide_w;

  // Bit mask and data for the masked update
  logic [15:0] mask_c;
  logic [15:0] data_c;
  always_comb begin
    mask_c = lmask_w;
    data_c = wdat16_w;
    if (mac_hi_w) begin
      mask_c = 16'hffff;
      data_c = {bdat_w, mac_lo_ff};
    end else if (op_w == host_map_pkg::OP_SET) begin
      // R4: ones in the data set bits
      mask_c = lmask_w & wdat16_w;
      data_c = 16'hffff;
    end else if (op_w == host_map_pkg::OP_CLR) begin
      // R4: ones in the data clear bits
      mask_c = lmask_w & wdat16_w;
      data_c = 16'h0000;
    end
  end

  // Pending flag: a new low byte wins over a commit
  always_comb begin
    nxt_mac_pend = mac_pend_ff;
    if (mac_lo_w) begin
      nxt_mac_pend = 1'b1;
    end else if (mac_hi_w) begin
      nxt_mac_pend = 1'b0;
    end
  end

  // Staging registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mac_pend_ff <= 1'b0;
      mac_idx_ff  <= 7'h00;
      mac_lo_ff   <= 8'h00;
    end else begin
      mac_pend_ff <= nxt_mac_pend;
      if (mac_lo_w) begin
        mac_idx_ff <= idx_w;
        mac_lo_ff  <= bdat_w;
      end
    end
  end

  // ==========================================================
  // Stage 1: registered request
  // ==========================================================
  host_map_pkg::region_t rgn_w;
  assign rgn_w = is_buf_w ? host_map_pkg::RGN_BUF :
                 is_csr_w ? host_map_pkg::RGN_CSR :
                            host_map_pkg::RGN_NONE;

  logic                  s1_valid_ff;  // Request in stage 1
  logic                  s1_rd_ff;     // It is a read
  host_map_pkg::region_t s1_rgn_ff;    // Target region
  logic                  s1_hi_ff;     // High byte on byte port
  logic                  s1_wide_ff;   // Whole word answer
  logic                  mem_we_ff;    // Register write strobe
  logic [6:0]            mem_idx_ff;   // Register word index
  logic [15:0]           mem_mask_ff;  // Bits to update
  logic [15:0]           mem_data_ff;  // New bit values

  // Stage 1 capture; stays short, all decoding is above
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_valid_ff <= 1'b0;
      s1_rd_ff    <= 1'b0;
      s1_rgn_ff   <= host_map_pkg::RGN_NONE;
      s1_hi_ff    <= 1'b0;
      s1_wide_ff  <= 1'b0;
      mem_we_ff   <= 1'b0;
      mem_idx_ff  <= 7'h00;
      mem_mask_ff <= 16'h0000;
      mem_data_ff <= 16'h0000;
    end else begin
      s1_valid_ff <= req_w;
      s1_rd_ff    <= req_w & ~wr_w;
      s1_rgn_ff   <= rgn_w;
      s1_hi_ff    <= is_buf_w ? par_byte_w[0] : hi_w;
      s1_wide_ff  <= wide_w;
      mem_we_ff   <= mem_we_w;
      mem_idx_ff  <= idx_w;
      mem_mask_ff <= mask_c;
      mem_data_ff <= data_c;
    end
  end

  // Buffer port; reads return one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_req_o   <= 1'b0;
      buf_wr_o    <= 1'b0;
      buf_addr_o  <= 15'h0000;
      buf_be_o    <= 2'b00;
      buf_wdata_o <= 16'h0000;
    end else begin
      buf_req_o   <= req_w & is_buf_w;
      buf_wr_o    <= req_w & is_buf_w & wr_w;
      buf_addr_o  <= par_byte_w;
      buf_be_o    <= lanes_w;
      buf_wdata_o <= wdat16_w;
    end
  end

  // ==========================================================
  // Register storage
  // ==========================================================
  logic [15:0] csr_rdata;   // Registered register word

  csr_word_mem #(
    .WORDS  (host_map_pkg::CSR_WORDS),
    .IDX_W  (7),
    .DATA_W (16)
  ) u_csr_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (mem_we_ff),
    .wr_idx_i  (mem_idx_ff),
    .wr_mask_i (mem_mask_ff),
    .wr_data_i (mem_data_ff),
    .rd_idx_i  (mem_idx_ff),
    .rd_data_o (csr_rdata)
  );

  // ==========================================================
  // Stage 2 and answer
  // ==========================================================
  logic                  s2_valid_ff;
  logic                  s2_rd_ff;
  host_map_pkg::region_t s2_rgn_ff;
  logic                  s2_hi_ff;
  logic                  s2_wide_ff;

  // Follows the storage read latency
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s2_valid_ff <= 1'b0;
      s2_rd_ff    <= 1'b0;
      s2_rgn_ff   <= host_map_pkg::RGN_NONE;
      s2_hi_ff    <= 1'b0;
      s2_wide_ff  <= 1'b0;
    end else begin
      s2_valid_ff <= s1_valid_ff;
      s2_rd_ff    <= s1_rd_ff;
      s2_rgn_ff   <= s1_rgn_ff;
      s2_hi_ff    <= s1_hi_ff;
      s2_wide_ff  <= s1_wide_ff;
    end
  end

  // Word from the addressed region
  logic [15:0] word_c;
  always_comb begin
    case (s2_rgn_ff)
      host_map_pkg::RGN_BUF:  word_c = buf_rdata_i;
      host_map_pkg::RGN_CSR:  word_c = csr_rdata;
      // R14: unimplemented and crypto read zero
      host_map_pkg::RGN_NONE: word_c = 16'h0000;
      default:                word_c = 16'h0000;
    endcase
  end

  // R13: byte port picks high half on odd address
  wire [15:0] ans_w = s2_wide_ff ? word_c :
                      {8'h00, (s2_hi_ff ? word_c[15:8] : word_c[7:0])};

  // Answer for every request; writes answer zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 16'h0000;
      mac_pend_o  <= 1'b0;
    end else begin
      rsp_valid_o <= s2_valid_ff;
      rsp_rdata_o <= s2_rd_ff ? ans_w : 16'h0000;
      mac_pend_o  <= nxt_mac_pend;
    end
  end

endmodule

// [tb/host_map_sva.sv]
module host_map_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Requests
  input wire logic        par_mode_i,
  input wire logic        par_wide_i,
  input wire logic        par_req_i,
  input wire logic        par_wr_i,
  input wire logic [14:0] par_addr_i,
  input wire logic [15:0] par_wdata_i,
  input wire logic        ser_req_i,
  input wire logic        ser_wr_i,
  input wire logic [1:0]  ser_op_i,
  input wire logic        ser_banked_i,
  input wire logic [7:0]  ser_addr_i,
  // Answers
  input wire logic        rsp_valid_o,
  input wire logic [15:0] rsp_rdata_o,
  input wire logic        buf_req_o,
  input wire logic        buf_wr_o,
  input wire logic [14:0] buf_addr_o,
  input wire logic [15:0] buf_wdata_o,
  input wire logic        mac_pend_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // Request decode
  // ====================
  wire logic p_take = par_req_i && par_mode_i;   // Parallel access
  wire logic s_take = ser_req_i && !par_mode_i;  // Serial access
  wire logic take   = p_take || s_take;
  // Byte-mode buffer hit
  wire logic b_buf  = p_take && !par_wide_i &&
                      par_addr_i <= host_map_pkg::BUF_END;
  wire logic in_cry = par_addr_i >= host_map_pkg::CRYPTO_LO &&
                      par_addr_i <= host_map_pkg::CRYPTO_HI;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ====================
  // Sequences
  // ====================
  // Plain serial write to a MAC low byte
  sequence s_mac_lo;
    s_take && ser_wr_i && ser_op_i == host_map_pkg::OP_WRITE &&
      !ser_banked_i && ser_addr_i == 8'h40;
  endsequence
  sequence s_answer;
    ##3 rsp_valid_o;
  endsequence

  // ====================
  // Properties
  // ====================
  property p_rsp_lat;
    take |-> s_answer;
  endproperty
  property p_rsp_src;
    rsp_valid_o |-> $past(take, 3);
  endproperty
  property p_buf_lim;
    buf_req_o |-> $past(p_take) && buf_addr_o <= host_map_pkg::BUF_END;
  endproperty
  property p_cry_blk;
    p_take && !par_wide_i && in_cry |-> ##1 !buf_req_o;
  endproperty
  property p_cry_zero;
    p_take && !par_wr_i && !par_wide_i && in_cry
      |-> ##3 rsp_rdata_o == 16'h0000;
  endproperty
  property p_word_addr;
    p_take && par_wide_i && par_addr_i < 15'h3000 |-> ##1 buf_req_o &&
      buf_addr_o == {$past(par_addr_i[13:0]), 1'b0};
  endproperty
  property p_byte_addr;
    b_buf |-> ##1 buf_req_o && buf_addr_o == $past(par_addr_i);
  endproperty
  property p_byte_dup;
    b_buf && par_wr_i |-> ##1 buf_wr_o &&
      buf_wdata_o == {2{$past(par_wdata_i[7:0])}};
  endproperty
  property p_ser_hi;
    s_take && !ser_wr_i |-> ##3 rsp_rdata_o[15:8] == 8'h00;
  endproperty
  property p_ser_top;
    s_take && !ser_wr_i && !ser_banked_i &&
      ser_addr_i >= host_map_pkg::CSR_BYTES |-> ##3 rsp_rdata_o == 16'h0000;
  endproperty
  property p_mac_stage;
    s_mac_lo |-> ##[1:3] mac_pend_o;
  endproperty

  // ====================
  // Assertions
  // ====================
  a_rsp_lat: assert property (p_rsp_lat)
    else $error("no answer");
  a_rsp_src: assert property (p_rsp_src)
    else $error("stray answer");
  a_buf_lim: assert property (p_buf_lim)
    else $error("buffer overrun");
  a_cry_blk: assert property (p_cry_blk)
    else $error("crypto reached");
  a_cry_zero: assert property (p_cry_zero)
    else $error("crypto read nonzero");
  a_word_addr: assert property (p_word_addr)
    else $error("word address wrong");
  a_byte_addr: assert property (p_byte_addr)
    else $error("byte address wrong");
  a_byte_dup: assert property (p_byte_dup)
    else $error("byte not on both lanes");
  a_ser_hi: assert property (p_ser_hi)
    else $error("serial high half nonzero");
  a_ser_top: assert property (p_ser_top)
    else $error("read past end nonzero");
  a_mac_stage: assert property (p_mac_stage)
    else $error("low byte not staged");
endmodule

bind host_register_address_map host_map_sva chk_u (.*);

// [tb/pkt_buf_model.sv]
module pkt_buf_model (
  // Clock
  input  wire logic        clk_i,
  // Buffer request from the block
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [15:0] wdata_i,
  // Read word, one cycle after request
  output logic      [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // Storage, 12K words
  // ====================
  logic [15:0] mem [0:12287];  // Word array
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    rdata_o = 16'h0000;
  end
  // Byte address picks the word, lanes pick bytes
  // byte pointer units
  always @(posedge clk_i) begin
    if (req_i && wr_i && be_i[0]) mem[addr_i[14:1]][7:0] <= wdata_i[7:0];
    if (req_i && wr_i && be_i[1]) mem[addr_i[14:1]][15:8] <= wdata_i[15:8];
    // Toggles outside reads, so stale data fails
    if (req_i && !wr_i) rdata_o <= mem[addr_i[14:1]];
    else rdata_o <= ~rdata_o;
  end
endmodule

// [tb/tb_host_register_address_map.sv]
module tb_host_register_address_map;
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // Signals
  // ====================
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        par_mode_i = 1'b0, par_wide_i = 1'b0;
  logic        par_req_i = 1'b0, par_wr_i = 1'b0;
  logic [14:0] par_addr_i = 15'h0000;
  logic [1:0]  par_be_i = 2'h0;
  logic [15:0] par_wdata_i = 16'h0000;
  logic        ser_req_i = 1'b0, ser_wr_i = 1'b0, ser_banked_i = 1'b0;
  logic [1:0]  ser_op_i = 2'h0, ser_bank_i = 2'h0;
  logic [4:0]  ser_off_i = 5'h00;
  logic [7:0]  ser_addr_i = 8'h00, ser_wdata_i = 8'h00;
  logic        rsp_valid_o, buf_req_o, buf_wr_o, mac_pend_o;
  logic [15:0] rsp_rdata_o, buf_wdata_o, buf_rdata_i;
  logic [14:0] buf_addr_o;
  logic [1:0]  buf_be_o;
  int          failures = 0;
  int          num_checks = 0;
  logic [15:0] q;
  // Row: flags {par,wide,banked,wr,op[1:0]}, addr, lanes, data/expect
  typedef struct packed {
    logic [5:0]  f;
    logic [14:0] a;
    logic [1:0]  be;
    logic [15:0] v;
  } row_t;
  row_t rows[$];

  always #12.5 clk_i = ~clk_i;  // 40 MHz

  host_register_address_map dut_u (.*);
  pkt_buf_model buf_u (.clk_i(clk_i), .req_i(buf_req_o), .wr_i(buf_wr_o),
    .addr_i(buf_addr_o), .be_i(buf_be_o), .wdata_i(buf_wdata_o),
    .rdata_o(buf_rdata_i));

  // ====================
  // Tasks
  // ====================
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic add(input logic [5:0] f, input logic [14:0] a,
                     input logic [15:0] v, input logic [1:0] be = 2'h3);
    rows.push_back({f, a, be, v});
  endtask

  // One access, then a bounded wait for the answer
  task automatic acc(input row_t r, output logic [15:0] q);
    int n = 0;
    @(posedge clk_i);
    par_mode_i <= r.f[5];
    par_wide_i <= r.f[4];
    @(posedge clk_i);
    par_req_i <= r.f[5];
    ser_req_i <= !r.f[5];
    par_wr_i <= r.f[2];
    ser_wr_i <= r.f[2];
    par_addr_i <= r.a;
    par_be_i <= r.be;
    par_wdata_i <= r.v;
    ser_op_i <= r.f[1:0];
    ser_banked_i <= r.f[3];
    {ser_bank_i, ser_off_i} <= r.a[6:0];
    ser_addr_i <= r.a[7:0];
    ser_wdata_i <= r.v[7:0];
    @(posedge clk_i);
    par_req_i <= 1'b0;
    ser_req_i <= 1'b0;
    #1;
    while (rsp_valid_o !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 8) begin
      failures++;
      $display("MISMATCH rsp_valid_o exp 1 seen 0");
      end_sim();
    end else q = rsp_rdata_o;
  endtask

  // ====================
  // Main sequence
  // ====================
  initial begin
    repeat (12) @(posedge clk_i);
    check("rsp_valid_o", 16'h0000, 16'(rsp_valid_o));
    rst_i <= 1'b0;
    add(6'h04,15'h0000,16'h00a5);
    add(6'h04,15'h0001,16'h003c);
    add(6'h00,15'h0000,16'h00a5);
    add(6'h20,15'h7e00,16'h00a5);
    add(6'h20,15'h7e01,16'h003c);
    add(6'h30,15'h3f00,16'h3ca5);
    add(6'h0c,15'h0056,16'h0077);
    add(6'h00,15'h0016,16'h0077);
    add(6'h08,15'h0076,16'h0077);
    add(6'h20,15'h7e36,16'h0077);
    add(6'h0c,15'h0025,16'h0011);
    add(6'h00,15'h0025,16'h0011);
    add(6'h04,15'h0085,16'h0099);
    add(6'h00,15'h0085,16'h0099);
    add(6'h08,15'h0005,16'h0000);
    add(6'h00,15'h009e,16'h0000);
    add(6'h00,15'h00a0,16'h0000);
    add(6'h24,15'h7e10,16'h00f0);
    add(6'h24,15'h7eb0,16'h000f);
    add(6'h20,15'h7e10,16'h00ff);
    add(6'h24,15'h7f50,16'h003c);
    add(6'h20,15'h7e10,16'h00c3);
    add(6'h04,15'h0040,16'h0012);
    add(6'h00,15'h0040,16'h0000);
    add(6'h04,15'h0041,16'h0034);
    add(6'h00,15'h0040,16'h0012);
    add(6'h00,15'h0041,16'h0034);
    add(6'h05,15'h0040,16'h00ff);
    add(6'h00,15'h0040,16'h0012);
    add(6'h04,15'h0043,16'h0055);
    add(6'h00,15'h0043,16'h0000);
    add(6'h34,15'h3f21,16'hbeef,2'h1);
    add(6'h30,15'h3f21,16'h0000);
    add(6'h34,15'h3f21,16'hbeef);
    add(6'h30,15'h3f21,16'hbeef);
    add(6'h24,15'h0001,16'h005a);
    add(6'h20,15'h0001,16'h005a);
    add(6'h34,15'h0010,16'h1234);
    add(6'h20,15'h0020,16'h0034);
    add(6'h20,15'h0021,16'h0012);
    add(6'h24,15'h5fff,16'h00c7);
    add(6'h30,15'h2fff,16'hc700);
    add(6'h24,15'h7800,16'h00ff);
    add(6'h20,15'h7800,16'h0000);
    add(6'h20,15'h7c4f,16'h0000);
    add(6'h20,15'h6000,16'h0000);
    // Writes answer zero
    foreach (rows[i]) begin
      acc(rows[i], q);
      check($sformatf("row%0d", i), rows[i].f[2] ? 16'h0000 : rows[i].v,
            q);
    end
    // Back-to-back serial write then read of an odd byte
    @(posedge clk_i);
    par_mode_i <= 1'b0;
    ser_req_i <= 1'b1;
    ser_wr_i <= 1'b1;
    ser_addr_i <= 8'h11;
    ser_wdata_i <= 8'h5e;
    @(posedge clk_i);
    ser_wr_i <= 1'b0;
    @(posedge clk_i);
    ser_req_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("first rsp", 16'h0001, 16'(rsp_valid_o));
    @(posedge clk_i);
    #1;
    check("second rsp", 16'h005e, rsp_valid_o ? rsp_rdata_o : 16'hdead);
    // Staged MAC low byte, then a reset in mid-run
    acc({6'h04, 15'h0042, 2'h3, 16'h0001}, q);
    check("mac_pend_o", 16'h0001, 16'(mac_pend_o));
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check("mac_pend_o", 16'h0000, 16'(mac_pend_o));
    @(posedge clk_i);
    rst_i <= 1'b0;
    acc({6'h00, 15'h0000, 2'h3, 16'h0000}, q);
    check("reg after reset", 16'h0000, q);
    end_sim();
  end
endmodule
